//--- rtl/input_board_defines.vh
// constants for the input board acquisition block
`ifndef INPUT_BOARD_DEFINES_VH
`define INPUT_BOARD_DEFINES_VH
// board clock
`define CLK_MHZ           50
// analog scan: 16 slots, currents 0-4, voltages 5-8, references 9-11, spares 12-15
`define NUM_CH_W          4
`define LAST_CH           4'hF
`define SMP_W             16
`define LAST_BIT          5'h0F
// mux settle time before each conversion, ns, and its cycle count (rounded up)
`define SETTLE_NS         2000
`define SETTLE_CYC        ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
// serial bit period is 8 clocks: phases 0-3 clock high, 4-7 low
`define PH_HIGH_END       3'h3
`define PH_LAST           3'h7
// sample instants per processing tick and per half-cycle filter
`define TICK_LAST         4'hB
`define HALF_CYC_CNT      4'hC
// digital inputs: 32 opto plus 4 on the combined board
`define NUM_DIN           36
// parallel bus byte addresses
`define A_DIN_BASE        2'h0
`define A_RLY_BASE        2'h1
`define A_FSEL_BASE       2'h2
`define A_IO              4'hC
`define A_IO_FSEL         4'hD
`define A_CAL_PTR         4'hE
`define A_CAL_DAT         4'hF
// reset values
`define FSEL_RST          32'hFFFFFFFF
`define IO_FSEL_RST       4'hF
`define RLY_RST           32'h00000000
`define IO_RLY_RST        4'h0
// sample buffer
`define FIFO_W            16
`define FIFO_DEPTH        16
`define FIFO_AW           4
`endif

//--- rtl/sample_fifo.v
// sample buffer between converter and serial link, registered read data
`timescale 1ns/1ps
module sample_fifo #(
  parameter W  = 16,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          ref_clk,
  input  wire          resetn,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output reg           out_valid,
  input  wire          out_ready,
  output reg  [W-1:0]  out_data
);
  reg  [W-1:0] mem [0:D-1];  // storage
  reg  [AW-1:0] wr_ptr;      // next write slot
  reg  [AW-1:0] rd_ptr;      // next read slot
  reg  [AW:0]   cnt;         // words held in mem
  wire          push;
  wire          pop;

  // full when mem holds D words; the output stage holds one more
  assign in_ready = (cnt != D[AW:0]);
  assign push     = in_valid && in_ready;
  // refill output register when empty or being taken
  assign pop      = (cnt != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  // storage write, no reset needed on data
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers, count and output stage
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      cnt       <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr    <= rd_ptr + 1'b1;
        out_data  <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule

//--- rtl/input_filter.v
// half-cycle persistence filter for one digital input
`timescale 1ns/1ps
`include "input_board_defines.vh"
module input_filter (
  input  wire ref_clk,
  input  wire resetn,
  input  wire raw,
  input  wire filt_en,
  input  wire instant,
  output reg  state
);
  reg [3:0] hold_cnt;  // sample instants the new level has persisted

  // filtered: accept after 12 instants of a steady new level;
  // timing off the tracking strobe keeps it at half a power cycle
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state    <= 1'b0;
      hold_cnt <= 4'h0;
    end else if (!filt_en) begin
      state    <= raw;
      hold_cnt <= 4'h0;
    end else if (raw == state) begin
      hold_cnt <= 4'h0;  // glitch gone, restart
    end else if (instant) begin
      if (hold_cnt == `HALF_CYC_CNT - 4'h1) begin
        state    <= raw;
        hold_cnt <= 4'h0;
      end else begin
        hold_cnt <= hold_cnt + 4'h1;
      end
    end
  end
endmodule

//--- rtl/input_board_acquisition.v
// input board acquisition: analog scan, sample link, digital inputs and relays
`timescale 1ns/1ps
`include "input_board_defines.vh"
// Overview of operation
// - mux steps sixteen channels into one converter
// - five current, four voltage channels, fixed slots
// - three slots sample reference voltages each scan
// - one scan per tracking strobe, 24 per cycle
// - sixteen-bit samples sent as serial bits
// - serial link carries only sample values
// - processor masters parallel bus, board only answers
// - calibration coefficients readable by the processor
// - eight digital inputs readable as a word
// - inputs filtered before latching into read buffer
// - per-input selectable half-cycle persistence filter
// - scales to thirty-two filtered readable inputs
// - processing tick every twelve sample instants
// - input change reported within half to one cycle
// - eight relay bits written and read back
// - up to thirty-two relay bits addressable
// - combined board: four inputs, four relays
module input_board_acquisition (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        track_strobe,
  output reg         proc_tick,
  output reg         scan_overrun,
  output reg  [3:0]  mux_sel,
  output reg         adc_cs_n,
  output reg         adc_sclk,
  input  wire        adc_sdata,
  output reg         ser_sclk,
  output reg         ser_fsync,
  output reg         ser_sdata,
  input  wire [31:0] opto_in,
  input  wire [3:0]  io_in,
  output reg  [31:0] relay_drive,
  output reg  [3:0]  io_relay,
  input  wire [3:0]  pbus_addr,
  input  wire        pbus_rd,
  input  wire        pbus_wr,
  input  wire [7:0]  pbus_data_in,
  output reg  [7:0]  pbus_data_out,
  output reg         pbus_data_oe,
  output reg  [7:0]  cal_addr,
  input  wire [7:0]  cal_rdata
);
  // scan sequencer states
  localparam [1:0] S_IDLE   = 2'd0;
  localparam [1:0] S_SETTLE = 2'd1;
  localparam [1:0] S_CONV   = 2'd2;
  localparam [1:0] S_PUSH   = 2'd3;
  // serial link states
  localparam [1:0] T_IDLE   = 2'd0;
  localparam [1:0] T_SHIFT  = 2'd1;
  localparam       SETTLE_I    = `SETTLE_CYC - 1;  // full-width last settle count
  localparam [6:0] SETTLE_LAST = SETTLE_I[6:0];
  localparam       SW = 52;  // width of the pin synchroniser

  // two-stage synchroniser for every pin from outside except resetn and cal_rdata
  reg  [SW-1:0] sync_meta;  // first stage, read only by sync_q
  reg  [SW-1:0] sync_q;     // second stage, safe to use
  wire [SW-1:0] sync_in;
  wire          strobe_s;   // tracking strobe, synced level
  wire          adc_s;      // converter serial data
  wire          rd_s;       // bus read strobe
  wire          wr_s;       // bus write strobe
  wire [3:0]    addr_s;     // bus address
  wire [7:0]    wdata_s;    // bus write data
  wire [35:0]   din_s;      // {io_in, opto_in}
  reg           strobe_d;   // for edge detect
  reg           wr_d;       // for edge detect
  wire          instant;    // one pulse per sample instant
  wire          wr_rise;    // one pulse per bus write

  assign sync_in  = {track_strobe, adc_sdata, pbus_rd, pbus_wr,
                     pbus_addr, pbus_data_in, io_in, opto_in};
  assign strobe_s = sync_q[51];
  assign adc_s    = sync_q[50];
  assign rd_s     = sync_q[49];
  assign wr_s     = sync_q[48];
  assign addr_s   = sync_q[47:44];
  assign wdata_s  = sync_q[43:36];
  assign din_s    = sync_q[35:0];
  assign instant  = strobe_s && !strobe_d;
  // address and data are held across the write strobe, so one-cycle
  // skew between synchroniser bits settles before the edge is used
  assign wr_rise  = wr_s && !wr_d;

  // pin synchroniser and edge history
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_meta <= {SW{1'b0}};
      sync_q    <= {SW{1'b0}};
      strobe_d  <= 1'b0;
      wr_d      <= 1'b0;
    end else begin
      sync_meta <= sync_in;
      sync_q    <= sync_meta;
      strobe_d  <= strobe_s;
      wr_d      <= wr_s;
    end
  end

  // processing tick: every 12th instant, two per power cycle
  reg [3:0] tick_cnt;  // instants since last tick
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt  <= 4'h0;
      proc_tick <= 1'b0;
    end else begin
      proc_tick <= 1'b0;
      if (instant) begin
        if (tick_cnt == `TICK_LAST) begin
          tick_cnt  <= 4'h0;
          proc_tick <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 4'h1;
        end
      end
    end
  end

  // ---- analog scan ----
  reg  [1:0]  scan_st;     // sequencer state
  reg  [6:0]  settle_cnt;  // mux settle timer
  reg  [2:0]  adc_ph;      // phase within one converter bit
  reg  [4:0]  adc_bit;     // bit index within the sample
  reg  [15:0] adc_shift;   // sample being assembled
  wire        fifo_in_ready;
  wire        fifo_in_valid;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [15:0] fifo_out_data;

  assign fifo_in_valid = (scan_st == S_PUSH);

  // every slot 0..15 is converted in ascending order: currents,
  // voltages, references and unused spares alike, so the frame
  // always has sixteen words in fixed positions
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scan_st      <= S_IDLE;
      mux_sel      <= 4'h0;
      settle_cnt   <= 7'h00;
      adc_ph       <= 3'h0;
      adc_bit      <= 5'h00;
      adc_shift    <= 16'h0000;
      adc_cs_n     <= 1'b1;
      adc_sclk     <= 1'b0;
      scan_overrun <= 1'b0;
    end else begin
      scan_overrun <= 1'b0;
      case (scan_st)
        S_IDLE: begin
          // a frame starts only on the strobe
          if (instant) begin
            mux_sel    <= 4'h0;
            settle_cnt <= 7'h00;
            scan_st    <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          // wait for mux output to settle, and for buffer room
          if (settle_cnt != SETTLE_LAST) begin
            settle_cnt <= settle_cnt + 7'h01;
          end else if (fifo_in_ready) begin
            adc_cs_n <= 1'b0;
            adc_ph   <= 3'h0;
            adc_bit  <= 5'h00;
            scan_st  <= S_CONV;
          end
        end
        S_CONV: begin
          // converter shifts on falling sclk; sync lag means adc_s at the
          // last high phase still holds the bit shown before that fall
          adc_ph   <= adc_ph + 3'h1;
          adc_sclk <= (adc_ph + 3'h1) <= `PH_HIGH_END;
          if (adc_ph == `PH_HIGH_END) adc_shift <= {adc_shift[14:0], adc_s};
          if (adc_ph == `PH_LAST) begin
            if (adc_bit == `LAST_BIT) begin
              adc_cs_n <= 1'b1;
              adc_sclk <= 1'b0;
              scan_st  <= S_PUSH;
            end else begin
              adc_bit <= adc_bit + 5'h01;
            end
          end
        end
        S_PUSH: begin
          // room was checked before converting, so push is taken now
          if (fifo_in_ready) begin
            if (mux_sel == `LAST_CH) begin
              scan_st <= S_IDLE;
            end else begin
              mux_sel    <= mux_sel + 4'h1;
              settle_cnt <= 7'h00;
              scan_st    <= S_SETTLE;
            end
          end
        end
        default: scan_st <= S_IDLE;
      endcase
      // strobe during a frame: frame rate too high, flag and carry on
      if (instant && scan_st != S_IDLE) begin
        scan_overrun <= 1'b1;
      end
    end
  end

  // sample buffer, 16 words of 16 bits
  sample_fifo #(
    .W  (`FIFO_W),
    .D  (`FIFO_DEPTH),
    .AW (`FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (adc_shift),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ---- serial sample link: data only, msb first ----
  reg  [1:0]  tx_st;     // link state
  reg  [2:0]  tx_ph;     // phase within one link bit
  reg  [4:0]  tx_bit;    // bit index
  reg  [15:0] tx_shift;  // word on the wire

  // the link stalls the buffer simply by not taking words
  assign fifo_out_ready = (tx_st == T_IDLE);

  // data changes on rising sclk, processor samples on falling;
  // fsync marks the first bit of every word
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_st     <= T_IDLE;
      tx_ph     <= 3'h0;
      tx_bit    <= 5'h00;
      tx_shift  <= 16'h0000;
      ser_sclk  <= 1'b0;
      ser_fsync <= 1'b0;
      ser_sdata <= 1'b0;
    end else begin
      case (tx_st)
        T_IDLE: begin
          ser_sclk  <= 1'b0;
          ser_fsync <= 1'b0;
          if (fifo_out_valid) begin
            tx_shift  <= fifo_out_data;
            ser_sdata <= fifo_out_data[15];
            ser_fsync <= 1'b1;
            ser_sclk  <= 1'b1;
            tx_ph     <= 3'h0;
            tx_bit    <= 5'h00;
            tx_st     <= T_SHIFT;
          end
        end
        T_SHIFT: begin
          tx_ph    <= tx_ph + 3'h1;
          ser_sclk <= (tx_ph + 3'h1) <= `PH_HIGH_END;
          if (tx_ph == `PH_LAST) begin
            ser_fsync <= 1'b0;
            if (tx_bit == `LAST_BIT) begin
              ser_sclk <= 1'b0;
              tx_st    <= T_IDLE;
            end else begin
              tx_bit    <= tx_bit + 5'h01;
              tx_shift  <= {tx_shift[14:0], 1'b0};
              ser_sdata <= tx_shift[14];
            end
          end
        end
        default: tx_st <= T_IDLE;
      endcase
    end
  end

  // ---- digital inputs ----
  reg  [31:0] filt_sel;     // filter enable per opto input
  reg  [3:0]  io_filt_sel;  // filter enable per combined-board input
  wire [35:0] filt_en;
  wire [35:0] din_filt;     // filtered levels
  reg  [35:0] din_buf;      // snapshot the processor reads

  assign filt_en = {io_filt_sel, filt_sel};

  // one filter per input, 32 opto plus 4 combined-board inputs
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_DIN; gi = gi + 1) begin : g_filt
      input_filter u_filt (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .raw     (din_s[gi]),
        .filt_en (filt_en[gi]),
        .instant (instant),
        .state   (din_filt[gi])
      );
    end
  endgenerate

  // buffer refreshed at each processing tick, so a change reaches
  // processing half to one cycle late depending on tick alignment
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      din_buf <= 36'h000000000;
    end else if (proc_tick) begin
      din_buf <= din_filt;
    end
  end

  // ---- parallel bus slave ----
  // the board never starts a cycle; it only answers rd and wr
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      relay_drive <= `RLY_RST;
      io_relay    <= `IO_RLY_RST;
      filt_sel    <= `FSEL_RST;
      io_filt_sel <= `IO_FSEL_RST;
      cal_addr    <= 8'h00;
    end else if (wr_rise) begin
      case (addr_s[3:2])
        `A_RLY_BASE:  relay_drive[{addr_s[1:0], 3'b000} +: 8] <= wdata_s;
        `A_FSEL_BASE: filt_sel[{addr_s[1:0], 3'b000} +: 8] <= wdata_s;
        default: begin
          // input bytes are read only; top group decoded below
          case (addr_s)
            `A_IO:      io_relay    <= wdata_s[7:4];
            `A_IO_FSEL: io_filt_sel <= wdata_s[3:0];
            `A_CAL_PTR: cal_addr    <= wdata_s;
            default:    cal_addr    <= cal_addr;
          endcase
        end
      endcase
    end
  end

  // read data driven while rd is held; bus released otherwise
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pbus_data_out <= 8'h00;
      pbus_data_oe  <= 1'b0;
    end else begin
      pbus_data_oe <= rd_s;
      case (addr_s[3:2])
        `A_DIN_BASE:  pbus_data_out <= din_buf[{addr_s[1:0], 3'b000} +: 8];
        `A_RLY_BASE:  pbus_data_out <= relay_drive[{addr_s[1:0], 3'b000} +: 8];
        `A_FSEL_BASE: pbus_data_out <= filt_sel[{addr_s[1:0], 3'b000} +: 8];
        default: begin
          case (addr_s)
            `A_IO:      pbus_data_out <= {io_relay, din_buf[35:32]};
            `A_IO_FSEL: pbus_data_out <= {4'h0, io_filt_sel};
            `A_CAL_PTR: pbus_data_out <= cal_addr;
            default:    pbus_data_out <= cal_rdata;
          endcase
        end
      endcase
    end
  end
endmodule

//--- sim/input_board_monitor.sv
// checker for the acquisition block ports
`timescale 1ns/1ps
module input_board_monitor (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       proc_tick,
  input wire logic       scan_overrun,
  input wire logic [3:0] mux_sel,
  input wire logic       adc_cs_n,
  input wire logic       adc_sclk,
  input wire logic       ser_sclk,
  input wire logic       ser_fsync,
  input wire logic       pbus_rd,
  input wire logic       pbus_data_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // low cycles of the converter select
  logic [8:0] cs_cnt;
  // counter instead of a 128-long repetition
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) cs_cnt <= 9'h000;
    else cs_cnt <= adc_cs_n ? 9'h000 : cs_cnt + 9'h001;
  end
  property p_tick_pulse; proc_tick |=> !proc_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick wider than one cycle");
  property p_ovr_pulse; scan_overrun |=> !scan_overrun; endproperty
  a_ovr_pulse: assert property (p_ovr_pulse) else $error("overrun wider than one cycle");
  property p_cs_len; $rose(adc_cs_n) |-> cs_cnt == 9'h080; endproperty
  a_cs_len: assert property (p_cs_len) else $error("conversion not 16 bits long");
  property p_sclk_idle; adc_cs_n |-> !adc_sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("bit clock outside conversion");
  property p_mux_step; $changed(mux_sel) && mux_sel != 4'h0 |-> mux_sel == $past(mux_sel) + 4'h1;
  endproperty
  a_mux_step: assert property (p_mux_step) else $error("slot order not ascending");
  property p_mux_hold; !adc_cs_n |-> $stable(mux_sel); endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("slot moved during conversion");
  property p_fs_len; $rose(ser_fsync) |-> ser_sclk ##0 ser_fsync[*8] ##1 !ser_fsync; endproperty
  a_fs_len: assert property (p_fs_len) else $error("frame sync not one bit long");
  property p_oe_on; $rose(pbus_rd) |-> ##[1:4] pbus_data_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("read not answered");
  property p_oe_off; !pbus_rd [*5] |-> !pbus_data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data driven without read");
endmodule
bind input_board_acquisition input_board_monitor mon (.ref_clk(ref_clk), .resetn(resetn),
  .proc_tick(proc_tick), .scan_overrun(scan_overrun), .mux_sel(mux_sel),
  .adc_cs_n(adc_cs_n), .adc_sclk(adc_sclk), .ser_sclk(ser_sclk), .ser_fsync(ser_fsync),
  .pbus_rd(pbus_rd), .pbus_data_oe(pbus_data_oe));

//--- sim/converter_link_model.sv
// converter model and sample link receiver
`timescale 1ns/1ps
module converter_link_model (
  input  wire logic [3:0] mux_sel,
  input  wire logic       adc_cs_n,
  input  wire logic       adc_sclk,
  output logic            adc_sdata,
  input  wire logic       ser_sclk,
  input  wire logic       ser_fsync,
  input  wire logic       ser_sdata
);
  logic [15:0] sh;        // converter shift register
  logic [15:0] rx;        // link receive shift
  int          nb = 0;    // bits of current word
  logic [15:0] rx_q[$];   // words seen on the link
  bit          fs_bad = 0; // frame sync out of place
  bit          armed = 0;  // set by a real rising link clock
  initial adc_sdata = 1'b0;
  // slot tagged into every word, so order faults show
  always @(negedge adc_cs_n) begin
    sh = {mux_sel, 4'h9, ~mux_sel, 4'h6};
    adc_sdata = sh[15];
  end
  // next bit after falling bit clock
  always @(negedge adc_sclk) begin
    if (!adc_cs_n) begin
      sh = {sh[14:0], 1'b0};
      adc_sdata = sh[15];
    end
  end
  // released line shows the inverse, not the last bit
  always @(posedge adc_cs_n) adc_sdata = ~adc_sdata;
  always @(posedge ser_sclk) armed = 1'b1;
  // processor port samples on falling link clock; the x-to-0 step
  // at reset is no clock edge and would skew word alignment
  always @(negedge ser_sclk) begin
    if (armed) begin
      armed = 1'b0;
      fs_bad = fs_bad | (ser_fsync != (nb == 0));
      rx = {rx[14:0], ser_sdata};
      nb++;
      if (nb == 16) begin
        rx_q.push_back(rx);
        nb = 0;
      end
    end
  end
endmodule

//--- sim/input_board_acquisition_tb.sv
// self-checking bench for the acquisition block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module input_board_acquisition_tb;
  logic        ref_clk = 0;
  logic        resetn = 0;
  logic        track_strobe = 0;
  logic [31:0] opto_in = 32'h00000000;
  logic [3:0]  io_in = 4'h0;
  logic [3:0]  pbus_addr = 4'h0;
  logic        pbus_rd = 0;
  logic        pbus_wr = 0;
  logic [7:0]  pbus_data_in = 8'h00;
  wire         proc_tick, scan_overrun, adc_cs_n, adc_sclk, adc_sdata;
  wire         ser_sclk, ser_fsync, ser_sdata, pbus_data_oe;
  wire  [3:0]  mux_sel, io_relay;
  wire  [31:0] relay_drive;
  wire  [7:0]  pbus_data_out, cal_addr;
  wire  [7:0]  cal_rdata = ~cal_addr; // calibration store stand-in
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          ticks = 0;
  int          ovrs = 0;
  logic [7:0]  d;
  input_board_acquisition uut (.ref_clk(ref_clk), .resetn(resetn),
    .track_strobe(track_strobe), .proc_tick(proc_tick), .scan_overrun(scan_overrun),
    .mux_sel(mux_sel), .adc_cs_n(adc_cs_n), .adc_sclk(adc_sclk), .adc_sdata(adc_sdata),
    .ser_sclk(ser_sclk), .ser_fsync(ser_fsync), .ser_sdata(ser_sdata),
    .opto_in(opto_in), .io_in(io_in), .relay_drive(relay_drive), .io_relay(io_relay),
    .pbus_addr(pbus_addr), .pbus_rd(pbus_rd), .pbus_wr(pbus_wr),
    .pbus_data_in(pbus_data_in), .pbus_data_out(pbus_data_out),
    .pbus_data_oe(pbus_data_oe), .cal_addr(cal_addr), .cal_rdata(cal_rdata));
  converter_link_model partner (.mux_sel(mux_sel), .adc_cs_n(adc_cs_n),
    .adc_sclk(adc_sclk), .adc_sdata(adc_sdata), .ser_sclk(ser_sclk),
    .ser_fsync(ser_fsync), .ser_sdata(ser_sdata));
  initial forever #10 ref_clk = ~ref_clk;
  // pulse counters and hang guard; limit well above the thirteen-frame run
  always @(posedge ref_clk) begin
    cyc++;
    if (proc_tick === 1'b1) ticks++;
    if (scan_overrun === 1'b1) ovrs++;
    if (cyc == 90000) begin
      err_total++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // addr and data settle 3 cycles before the write strobe
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk) begin pbus_addr <= a; pbus_data_in <= v; end
    repeat (3) @(posedge ref_clk);
    pbus_wr <= 1'b1;
    repeat (3) @(posedge ref_clk);
    pbus_wr <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk) begin pbus_addr <= a; pbus_rd <= 1'b1; end
    repeat (5) @(posedge ref_clk);
    `CHK("read enable", 1'b1, pbus_data_oe)
    v = pbus_data_out;
    pbus_rd <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic strobe();
    @(posedge ref_clk) track_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    track_strobe <= 1'b0;
  endtask
  // reset values, relay write and read back, refused writes, calibration
  task automatic t_bus();
    int k;
    `CHK("relays at reset", 32'h00000000, relay_drive)
    for (k = 8; k < 12; k++) begin
      bus_rd(k[3:0], d);
      `CHK("filter select", 8'hFF, d)
    end
    bus_rd(4'hD, d);
    `CHK("io filter select", 4'hF, d[3:0])
    for (k = 4; k < 8; k++) bus_wr(k[3:0], 8'h11 * k[7:0]);
    `CHK("relay drive", 32'h77665544, relay_drive)
    for (k = 4; k < 8; k++) begin
      bus_rd(k[3:0], d);
      `CHK("relay read back", 8'h11 * k[7:0], d)
    end
    bus_wr(4'hC, 8'hA0);
    `CHK("io relays", 4'hA, io_relay)
    bus_wr(4'h0, 8'hFF);
    bus_rd(4'h0, d);
    `CHK("input byte after write", 8'h00, d)
    bus_wr(4'hE, 8'h3C);
    `CHK("cal pointer", 8'h3C, cal_addr)
    bus_rd(4'hF, d);
    `CHK("cal data", 8'hC3, d)
  endtask
  // one frame: sixteen words, ascending slots, spares included
  task automatic t_frame();
    int k;
    bus_wr(4'h8, 8'h00);
    opto_in <= 32'h000000A5;
    io_in <= 4'h5;
    strobe();
    for (k = 0; k < 5000 && partner.rx_q.size() < 16; k++) @(posedge ref_clk);
    `CHK("words per frame", 16, partner.rx_q.size())
    for (k = 0; k < 16 && partner.rx_q.size() > 0; k++)
      `CHK("slot word", {k[3:0], 4'h9, ~k[3:0], 4'h6}, partner.rx_q.pop_front())
    `CHK("frame sync place", 1'b0, partner.fs_bad)
    bus_rd(4'h0, d);
    `CHK("input byte before tick", 8'h00, d)
  endtask
  // eleven more instants make the twelfth and the tick
  task automatic t_tick();
    int k;
    for (k = 0; k < 11; k++) begin
      repeat (3800) @(posedge ref_clk);
      strobe();
    end
    repeat (200) @(posedge ref_clk);
    `CHK("tick count", 1, ticks)
    bus_rd(4'h0, d);
    `CHK("input byte after tick", 8'hA5, d)
    bus_rd(4'hC, d);
    `CHK("io inputs and relays", 8'hA5, d)
  endtask
  // strobe in mid-scan is flagged and does not restart
  task automatic t_overrun();
    repeat (3800) @(posedge ref_clk);
    `CHK("link words", 176, partner.rx_q.size())
    strobe();
    repeat (300) @(posedge ref_clk);
    strobe();
    repeat (20) @(posedge ref_clk);
    `CHK("overrun count", 1, ovrs)
    repeat (4000) @(posedge ref_clk);
    `CHK("frame sync place", 1'b0, partner.fs_bad)
    `CHK("link words after overrun", 192, partner.rx_q.size())
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_bus();
    t_frame();
    t_tick();
    t_overrun();
    conclude();
  end
endmodule
